// File: pch_pkg.sv
package pch_pkg;

   // Data path shape toward the memory controller
   localparam int MEM_DATA_WIDTH = 16;
   localparam int RATE_RATIO = 2;
   localparam int WDATA_W = MEM_DATA_WIDTH * RATE_RATIO;
   localparam int ADDR_W = 24;
   localparam int BURST_LEN_WIDTH = 2;
   localparam logic [BURST_LEN_WIDTH-1:0] BURST_SIZE_ONE = 2'h1;

   // Register byte offsets on the bus
   localparam int WB_ADR_W = 8;
   localparam logic [WB_ADR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [WB_ADR_W-1:0] OFS_ADDR = 8'h04;
   localparam logic [WB_ADR_W-1:0] OFS_WDATA = 8'h08;
   localparam logic [WB_ADR_W-1:0] OFS_CMD = 8'h0C;
   localparam logic [WB_ADR_W-1:0] OFS_STATUS = 8'h10;

   // Launch edge setting held in CTRL[1:0]
   localparam int EDGE_W = 2;
   localparam logic [EDGE_W-1:0] EDGE_RISING = 2'h0;
   localparam logic [EDGE_W-1:0] EDGE_FALLING = 2'h1;
   localparam logic [EDGE_W-1:0] EDGE_EXTERNAL_SELECT = 2'h2;
   localparam logic [EDGE_W-1:0] CTRL_RESET = EDGE_EXTERNAL_SELECT;

   // CMD write bits
   localparam int CMD_READ_BIT = 0;
   localparam int CMD_WRITE_BIT = 1;
   localparam int CMD_REFRESH_BIT = 2;

   // STATUS bits
   localparam int ST_CAL_DONE = 0;
   localparam int ST_CALIBRATING = 1;
   localparam int ST_REQ_BUSY = 2;
   localparam int ST_REF_BUSY = 3;
   localparam int ST_WDREQ_SEEN = 4;
   localparam int ST_REF_ACKED = 5;
   localparam int ST_FALLING = 6;
   localparam int ST_REFUSED = 7;
   localparam int STATUS_W = 8;

   // Calibration run time after init done
   localparam int CAL_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CAL_CYCLES_INT = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_CNT_W = 8;
   localparam logic [CAL_CNT_W-1:0] CAL_CYCLES = CAL_CYCLES_INT[CAL_CNT_W-1:0];

   typedef enum logic [1:0] {
      CAL_WAIT_INIT,
      CAL_RUN,
      CAL_READY
   } pch_cal_state_t;

endpackage

// File: pch_req_if.sv
`timescale 1ns/100ps
// Request launch path between register side and handshake engine
interface pch_req_if;
   logic rd_start;
   logic wr_start;
   logic ref_start;
   logic [pch_pkg::ADDR_W-1:0] addr;
   logic req_busy;
   logic ref_busy;
   logic ref_acked;
   logic req_taken;

   modport regs (
      output rd_start, wr_start, ref_start, addr,
      input req_busy, ref_busy, ref_acked, req_taken
   );
   modport eng (
      input rd_start, wr_start, ref_start, addr,
      output req_busy, ref_busy, ref_acked, req_taken
   );
endinterface

// File: pch_req_engine.sv
`timescale 1ns/100ps
module pch_req_engine (
   input wire logic mclk, // System clock
   input wire logic nrst, // Async reset, active low
   pch_req_if.eng req, // Launch requests from register side
   input wire logic ctl_ready, // Controller took the request
   input wire logic ctl_refresh_ack, // Controller confirmed refresh
   output logic ctl_read_req, // Read request to controller
   output logic ctl_write_req, // Write request to controller
   output logic [pch_pkg::ADDR_W-1:0] ctl_address, // Request address
   output logic ctl_refresh_req // Refresh request to controller
);

   logic rd_q;
   logic wr_q;
   logic ref_q;
   logic [pch_pkg::ADDR_W-1:0] addr_q;
   logic taken;

   // Address captured when both request and accept are high
   assign taken = (rd_q | wr_q) & ctl_ready;

   ////////////////////////////////////////////////////////////////////////
   // Read and write request hold until accepted
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else if (taken) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else if (!rd_q && !wr_q) begin
         // Only one of the two is ever launched; read wins a tie
         rd_q <= req.rd_start;
         wr_q <= req.wr_start & ~req.rd_start;
      end
   end

   // Address stays frozen while a request is outstanding
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= '0;
      end else if (!rd_q && !wr_q && (req.rd_start || req.wr_start)) begin
         addr_q <= req.addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Refresh request held until the controller acknowledges
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ref_q <= 1'b0;
      end else if (ref_q && ctl_refresh_ack) begin
         ref_q <= 1'b0;
      end else if (req.ref_start) begin
         ref_q <= 1'b1;
      end
   end

   assign ctl_read_req = rd_q;
   assign ctl_write_req = wr_q;
   assign ctl_address = addr_q;
   assign ctl_refresh_req = ref_q;
   assign req.req_busy = rd_q | wr_q;
   assign req.ref_busy = ref_q;
   assign req.ref_acked = ref_q & ctl_refresh_ack;
   assign req.req_taken = taken;

endmodule

// File: pch_top.sv
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
// How it works
// - Calibration starts once controller reports init done
// - External select: falling-edge input picks launch edge
// - Read request output asks read at address
// - Accept plus request high captures the address
// - Burst size output is fixed at one
// - Ready flag rises only after calibration finishes
// - Write data width is data width times ratio
// - Write request output asks write at address
// - Refresh request held until controller acknowledges
// - Address output belongs to the raised request
module pch_top (
   input wire logic mclk, // System clock, 100 MHz
   input wire logic nrst, // Async reset, active low
   // Wishbone slave
   input wire logic [pch_pkg::WB_ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   input wire logic [3:0] wb_sel_i, // Byte lane selects
   input wire logic wb_we_i, // Write enable
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Strobe
   output logic wb_ack_o, // Acknowledge
   // Memory controller side
   input wire logic ctl_init_done, // Controller finished memory init
   input wire logic ctl_negedge_en, // Falling-edge launch select
   output logic ctl_read_req, // Read request
   input wire logic ctl_ready, // Request accepted
   output logic [pch_pkg::BURST_LEN_WIDTH-1:0] ctl_size, // Burst size
   output logic ctl_usr_mode_rdy, // Calibration finished
   output logic [pch_pkg::WDATA_W-1:0] ctl_wdata, // Write data
   input wire logic ctl_wdata_req, // Controller asks for write data
   output logic ctl_write_req, // Write request
   output logic [pch_pkg::ADDR_W-1:0] ctl_address, // Request address
   input wire logic ctl_refresh_ack, // Refresh acknowledge
   output logic ctl_refresh_req, // Refresh request
   output logic cal_active, // Calibration in progress
   output logic cmd_launch_falling // Launch address/command on falling edge
);

   ////////////////////////////////////////////////////////////////////////
   // Byte-lane merge shared by the CTRL, ADDR and WDATA registers
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   pch_req_if req ();

   logic ack_q;
   logic [31:0] rdat_q;
   logic wr_stb;
   logic [pch_pkg::EDGE_W-1:0] edge_q;
   logic [pch_pkg::ADDR_W-1:0] addr_q;
   logic [pch_pkg::WDATA_W-1:0] wdata_q;
   logic [31:0] ctrl_new;
   logic [31:0] addr_new;
   logic [31:0] wdata_new;
   logic [31:0] rd_mux;
   logic [pch_pkg::STATUS_W-1:0] status;
   logic cal_done;
   logic falling_d;
   logic falling_q;
   logic wdreq_seen_q;
   logic ref_acked_q;
   logic refused_q;
   logic cmd_wr;
   logic want_rd;
   logic want_wr;
   logic want_ref;
   logic rw_ok;
   logic ref_ok;
   logic refused_now;
   logic clr_wdreq;
   logic clr_refack;
   logic clr_refused;
   pch_pkg::pch_cal_state_t cal_q;
   logic [pch_pkg::CAL_CNT_W-1:0] cal_cnt_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: ack one cycle after strobe, dropped the cycle after
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end

   // Writes land on the edge where the master sees ack
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

   // Read data is snapshot when the access is first seen
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdat_q <= '0;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         rdat_q <= rd_mux;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Unmapped offsets read as zero and ignore writes
   always_comb begin
      rd_mux = '0;
      unique case (wb_adr_i)
         pch_pkg::OFS_CTRL: rd_mux[pch_pkg::EDGE_W-1:0] = edge_q;
         pch_pkg::OFS_ADDR: rd_mux[pch_pkg::ADDR_W-1:0] = addr_q;
         pch_pkg::OFS_WDATA: rd_mux[pch_pkg::WDATA_W-1:0] = wdata_q;
         pch_pkg::OFS_STATUS: rd_mux[pch_pkg::STATUS_W-1:0] = status;
         default: rd_mux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   assign ctrl_new = merge_sel({30'h0, edge_q}, wb_dat_i, wb_sel_i);
   assign addr_new = merge_sel({8'h0, addr_q}, wb_dat_i, wb_sel_i);
   assign wdata_new = merge_sel(wdata_q, wb_dat_i, wb_sel_i);

   // Launch edge setting
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         edge_q <= pch_pkg::CTRL_RESET;
      end else if (wr_stb && wb_adr_i == pch_pkg::OFS_CTRL) begin
         edge_q <= ctrl_new[pch_pkg::EDGE_W-1:0];
      end
   end

   // Staged request address, copied into the engine at launch
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= '0;
      end else if (wr_stb && wb_adr_i == pch_pkg::OFS_ADDR) begin
         addr_q <= addr_new[pch_pkg::ADDR_W-1:0];
      end
   end

   // Write data held steady for the controller to fetch
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wdata_q <= '0;
      end else if (wr_stb && wb_adr_i == pch_pkg::OFS_WDATA) begin
         wdata_q <= wdata_new;
      end
   end

   assign ctl_wdata = wdata_q;
   assign ctl_size = pch_pkg::BURST_SIZE_ONE;

   ////////////////////////////////////////////////////////////////////////
   // Launch edge: a mode of 3 is treated as rising
   always_comb begin
      unique case (edge_q)
         pch_pkg::EDGE_FALLING: falling_d = 1'b1;
         pch_pkg::EDGE_EXTERNAL_SELECT: falling_d = ctl_negedge_en;
         default: falling_d = 1'b0;
      endcase
   end

   // Registered so the double-rate launch logic sees a clean level
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         falling_q <= 1'b0;
      end else begin
         falling_q <= falling_d;
      end
   end

   assign cmd_launch_falling = falling_q;

   ////////////////////////////////////////////////////////////////////////
   // Calibration sequencer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cal_q <= pch_pkg::CAL_WAIT_INIT;
      end else begin
         unique case (cal_q)
            pch_pkg::CAL_WAIT_INIT: begin
               if (ctl_init_done) begin
                  cal_q <= pch_pkg::CAL_RUN;
               end
            end
            pch_pkg::CAL_RUN: begin
               if (!ctl_init_done) begin
                  cal_q <= pch_pkg::CAL_WAIT_INIT;
               end else if (cal_cnt_q == pch_pkg::CAL_CYCLES - 8'h01) begin
                  cal_q <= pch_pkg::CAL_READY;
               end
            end
            pch_pkg::CAL_READY: begin
               // Losing init done means the memory was reset under us
               if (!ctl_init_done) begin
                  cal_q <= pch_pkg::CAL_WAIT_INIT;
               end
            end
         endcase
      end
   end

   // Calibration time counter
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cal_cnt_q <= '0;
      end else if (cal_q == pch_pkg::CAL_RUN) begin
         cal_cnt_q <= cal_cnt_q + 8'h01;
      end else begin
         cal_cnt_q <= '0;
      end
   end

   assign cal_done = (cal_q == pch_pkg::CAL_READY);
   assign cal_active = (cal_q == pch_pkg::CAL_RUN);
   assign ctl_usr_mode_rdy = cal_done;

   ////////////////////////////////////////////////////////////////////////
   // Command launch; refused while uncalibrated or still busy
   assign cmd_wr = wr_stb && wb_adr_i == pch_pkg::OFS_CMD && wb_sel_i[0];
   assign want_rd = cmd_wr & wb_dat_i[pch_pkg::CMD_READ_BIT];
   assign want_wr = cmd_wr & wb_dat_i[pch_pkg::CMD_WRITE_BIT];
   assign want_ref = cmd_wr & wb_dat_i[pch_pkg::CMD_REFRESH_BIT];
   assign rw_ok = cal_done & ~req.req_busy;
   assign ref_ok = cal_done & ~req.ref_busy;
   // Asking read and write together is refused as ambiguous
   assign refused_now = ((want_rd | want_wr) & (~rw_ok | (want_rd & want_wr)))
                        | (want_ref & ~ref_ok);

   assign req.rd_start = want_rd & ~want_wr & rw_ok;
   assign req.wr_start = want_wr & ~want_rd & rw_ok;
   assign req.ref_start = want_ref & ref_ok;
   assign req.addr = addr_q;

   pch_req_engine u_engine (
      .mclk(mclk),
      .nrst(nrst),
      .req(req),
      .ctl_ready(ctl_ready),
      .ctl_refresh_ack(ctl_refresh_ack),
      .ctl_read_req(ctl_read_req),
      .ctl_write_req(ctl_write_req),
      .ctl_address(ctl_address),
      .ctl_refresh_req(ctl_refresh_req)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sticky status: write one to clear, a new event wins over the clear
   assign clr_wdreq = wr_stb && wb_adr_i == pch_pkg::OFS_STATUS && wb_sel_i[0]
                      && wb_dat_i[pch_pkg::ST_WDREQ_SEEN];
   assign clr_refack = wr_stb && wb_adr_i == pch_pkg::OFS_STATUS && wb_sel_i[0]
                       && wb_dat_i[pch_pkg::ST_REF_ACKED];
   assign clr_refused = wr_stb && wb_adr_i == pch_pkg::OFS_STATUS && wb_sel_i[0]
                        && wb_dat_i[pch_pkg::ST_REFUSED];

   // Controller fetched write data; optional for streaming controllers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wdreq_seen_q <= 1'b0;
      end else if (ctl_wdata_req) begin
         wdreq_seen_q <= 1'b1;
      end else if (clr_wdreq) begin
         wdreq_seen_q <= 1'b0;
      end
   end

   // Refresh handshake completed
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ref_acked_q <= 1'b0;
      end else if (req.ref_acked) begin
         ref_acked_q <= 1'b1;
      end else if (clr_refack) begin
         ref_acked_q <= 1'b0;
      end
   end

   // A command was dropped
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         refused_q <= 1'b0;
      end else if (refused_now) begin
         refused_q <= 1'b1;
      end else if (clr_refused) begin
         refused_q <= 1'b0;
      end
   end

   // Status word as software reads it
   always_comb begin
      status = '0;
      status[pch_pkg::ST_CAL_DONE] = cal_done;
      status[pch_pkg::ST_CALIBRATING] = cal_active;
      status[pch_pkg::ST_REQ_BUSY] = req.req_busy;
      status[pch_pkg::ST_REF_BUSY] = req.ref_busy;
      status[pch_pkg::ST_WDREQ_SEEN] = wdreq_seen_q;
      status[pch_pkg::ST_REF_ACKED] = ref_acked_q;
      status[pch_pkg::ST_FALLING] = falling_q;
      status[pch_pkg::ST_REFUSED] = refused_q;
   end

endmodule

// File: pch_top_asserts.sv
`timescale 1ns/100ps
module pch_top_asserts (
   input wire logic mclk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_ack_o, // Bus ack
   input wire logic ctl_init_done, // Init done
   input wire logic ctl_read_req, // Read request
   input wire logic ctl_write_req, // Write request
   input wire logic ctl_ready, // Accept
   input wire logic [pch_pkg::ADDR_W-1:0] ctl_address, // Address
   input wire logic [pch_pkg::BURST_LEN_WIDTH-1:0] ctl_size, // Burst size
   input wire logic ctl_usr_mode_rdy, // Calibrated
   input wire logic ctl_refresh_req, // Refresh request
   input wire logic ctl_refresh_ack, // Refresh ack
   input wire logic cal_active // Calibrating
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [pch_pkg::CAL_CNT_W-1:0] cal_n_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Length of the running calibration, so its exact span can be checked
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         cal_n_q <= '0;
      else if (cal_active)
         cal_n_q <= cal_n_q + 1'b1;
      else
         cal_n_q <= '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_size_fixed: assert property (ctl_size == pch_pkg::BURST_SIZE_ONE)
      else $error("burst size not one");
   a_cal_starts: assert property (ctl_init_done && !cal_active && !ctl_usr_mode_rdy |=> cal_active)
      else $error("calibration did not start");
   a_rdy_after_cal: assert property ($rose(ctl_usr_mode_rdy) |-> $past(cal_active))
      else $error("ready without calibration");
   a_cal_span: assert property ($fell(cal_active) && ctl_usr_mode_rdy |-> cal_n_q == pch_pkg::CAL_CYCLES)
      else $error("calibration span wrong");
   a_rw_needs_rdy: assert property ($rose(ctl_read_req || ctl_write_req) |-> ctl_usr_mode_rdy)
      else $error("request before calibration");
   a_rd_holds: assert property (ctl_read_req && !ctl_ready |=> ctl_read_req && $stable(ctl_address))
      else $error("read request not held");
   a_wr_holds: assert property (ctl_write_req && !ctl_ready |=> ctl_write_req && $stable(ctl_address))
      else $error("write request not held");
   a_rw_drops: assert property ((ctl_read_req || ctl_write_req) && ctl_ready |=> !(ctl_read_req || ctl_write_req))
      else $error("request kept after accept");
   a_one_rw: assert property (!(ctl_read_req && ctl_write_req))
      else $error("read and write together");
   a_ref_holds: assert property (ctl_refresh_req && !ctl_refresh_ack |=> ctl_refresh_req)
      else $error("refresh dropped early");
   a_ref_drops: assert property (ctl_refresh_req && ctl_refresh_ack |=> !ctl_refresh_req)
      else $error("refresh kept after ack");
   a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack timing wrong");
   c_read: cover property (ctl_read_req && ctl_ready);
   c_write: cover property (ctl_write_req && ctl_ready);
   c_refresh: cover property (ctl_refresh_req && ctl_refresh_ack);
endmodule
bind pch_top pch_top_asserts u_chk (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ctl_init_done(ctl_init_done),
   .ctl_read_req(ctl_read_req), .ctl_write_req(ctl_write_req), .ctl_ready(ctl_ready),
   .ctl_address(ctl_address), .ctl_size(ctl_size), .ctl_usr_mode_rdy(ctl_usr_mode_rdy),
   .ctl_refresh_req(ctl_refresh_req), .ctl_refresh_ack(ctl_refresh_ack),
   .cal_active(cal_active));

// File: pch_ctl_model.sv
`timescale 1ns/100ps
module pch_ctl_model (
   input wire logic mclk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic [3:0] lat, // Wait cycles before answering
   input wire logic rd_req, // Read request
   input wire logic wr_req, // Write request
   input wire logic ref_req, // Refresh request
   output logic ready, // Accept
   output logic ref_ack, // Refresh ack
   output logic wd_req // Write data request
);
   logic [3:0] rc_q;
   logic [3:0] fc_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Accept only a pending request, after lat cycles; one-cycle pulse
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ready <= 1'b0;
         rc_q <= 4'h0;
      end else if (ready || !(rd_req || wr_req)) begin
         ready <= 1'b0;
         rc_q <= 4'h0;
      end else if (rc_q >= lat) begin
         ready <= 1'b1;
      end else begin
         rc_q <= rc_q + 4'h1;
      end
   end
   // Refresh is answered on its own timer, independent of reads and writes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ref_ack <= 1'b0;
         fc_q <= 4'h0;
      end else if (ref_ack || !ref_req) begin
         ref_ack <= 1'b0;
         fc_q <= 4'h0;
      end else if (fc_q >= lat) begin
         ref_ack <= 1'b1;
      end else begin
         fc_q <= fc_q + 4'h1;
      end
   end
   // Ask for write data while a write is pending, in alternate cycles
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         wd_req <= 1'b0;
      else
         wd_req <= wr_req && !wd_req;
   end
endmodule

// File: test_pch_top.sv
`timescale 1ns/100ps
module test_pch_top;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dw = 32'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic init_done = 1'b0;
   logic neg_en = 1'b0;
   logic [3:0] lat = 4'h0;
   logic [31:0] dr, q;
   logic ack, rd, wr, rf, ready, rf_ack, wd_req, usr_rdy, cal_act, fall;
   logic [1:0] size, acc_kind;
   logic [31:0] wdata;
   logic [23:0] addr, acc_addr;
   int evt_n = 0;
   int num_errors = 0;
   int tests_run = 0;
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   pch_top uut (.mclk(mclk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
      .ctl_init_done(init_done), .ctl_negedge_en(neg_en), .ctl_read_req(rd),
      .ctl_ready(ready), .ctl_size(size), .ctl_usr_mode_rdy(usr_rdy), .ctl_wdata(wdata),
      .ctl_wdata_req(wd_req), .ctl_write_req(wr), .ctl_address(addr),
      .ctl_refresh_ack(rf_ack), .ctl_refresh_req(rf), .cal_active(cal_act),
      .cmd_launch_falling(fall));
   pch_ctl_model u_ctl (.mclk(mclk), .nrst(nrst), .lat(lat), .rd_req(rd), .wr_req(wr),
      .ref_req(rf), .ready(ready), .ref_ack(rf_ack), .wd_req(wd_req));
   // Note what the controller took at each accepting edge
   always @(posedge mclk) begin
      if ((rd || wr) && ready) begin
         acc_addr <= addr;
         acc_kind <= {wr, rd};
         evt_n <= evt_n + 1;
      end
      if (rf && rf_ack)
         evt_n <= evt_n + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic hang(input string nm);
      $display("ERROR %s expected done seen timeout", nm);
      num_errors++;
      finish_test();
   endtask
   // One classic cycle; read data is taken at the ack edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      we <= w;
      dw <= d;
      cyc <= 1'b1;
      @(posedge mclk);
      while (ack !== 1'b1) begin
         n++;
         if (n > 20)
            hang("bus ack");
         @(posedge mclk);
      end
      q = dr;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wait_evt(input int n0);
      int n;
      n = 0;
      while (evt_n == n0) begin
         n++;
         if (n > 60)
            hang("accept");
         @(posedge mclk);
      end
   endtask
   function automatic logic exp_fall(input logic [1:0] m, input logic n);
      return (m == pch_pkg::EDGE_FALLING) | ((m == pch_pkg::EDGE_EXTERNAL_SELECT) & n);
   endfunction
   task automatic do_rw(input logic w, input logic [23:0] a, input logic [31:0] d);
      int n0;
      logic [31:0] c;
      c = 32'h1 << (w ? pch_pkg::CMD_WRITE_BIT : pch_pkg::CMD_READ_BIT);
      wb(pch_pkg::OFS_ADDR, 1'b1, {8'h00, a});
      wb(pch_pkg::OFS_WDATA, 1'b1, d);
      lat <= 4'($urandom_range(0, 7));
      n0 = evt_n;
      wb(pch_pkg::OFS_CMD, 1'b1, c);
      wait_evt(n0);
      chk("accepted address", {8'h00, a}, {8'h00, acc_addr});
      chk("request kind", c, {30'h0, acc_kind});
      chk("write data", d, wdata);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, early refusal, calibration, edges, traffic, refresh
   initial begin
      int i, n0;
      i = $urandom(51);
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      chk("size", {30'h0, pch_pkg::BURST_SIZE_ONE}, {30'h0, size});
      chk("wdata width", pch_pkg::MEM_DATA_WIDTH * pch_pkg::RATE_RATIO, $bits(wdata));
      wb(pch_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("ctrl reset", {30'h0, pch_pkg::CTRL_RESET}, q);
      wb(8'h40, 1'b1, 32'hFFFFFFFF);
      wb(8'h40, 1'b0, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(pch_pkg::OFS_CMD, 1'b1, 32'h1);
      wb(pch_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("early refused", 32'h80, q & 32'h81);
      chk("early accepts", 32'h0, 32'(evt_n));
      wb(pch_pkg::OFS_STATUS, 1'b1, 32'h80);
      init_done <= 1'b1;
      i = 0;
      while (usr_rdy !== 1'b1) begin
         i++;
         if (i > 300)
            hang("calibration");
         if (i == 50)
            chk("calibrating", 32'h1, {31'h0, cal_act});
         @(posedge mclk);
      end
      chk("cal long enough", 32'h1, {31'h0, i >= pch_pkg::CAL_CYCLES_INT});
      for (i = 0; i < 8; i++) begin
         wb(pch_pkg::OFS_CTRL, 1'b1, 32'(i >> 1));
         neg_en <= i[0];
         repeat (2) @(posedge mclk);
         chk("launch edge", {31'h0, exp_fall(2'(i >> 1), i[0])}, {31'h0, fall});
      end
      do_rw(1'b1, 24'hFFFFFF, 32'hFFFFFFFF);
      do_rw(1'b0, 24'h000000, 32'h0);
      for (i = 0; i < 10; i++)
         do_rw(1'($urandom), 24'($urandom), $urandom);
      // A slow accept: a second command meanwhile must be turned away
      lat <= 4'hF;
      n0 = evt_n;
      wb(pch_pkg::OFS_CMD, 1'b1, 32'h1);
      wb(pch_pkg::OFS_CMD, 1'b1, 32'h2);
      wb(pch_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("busy refused", 32'h84, q & 32'h84);
      wait_evt(n0);
      chk("first kept", 32'h1, {30'h0, acc_kind});
      wb(pch_pkg::OFS_STATUS, 1'b1, 32'h80);
      n0 = evt_n;
      wb(pch_pkg::OFS_CMD, 1'b1, 32'h3);
      repeat (20) @(posedge mclk);
      wb(pch_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("both refused", 32'h80, q & 32'h84);
      chk("no accept", 32'(n0), 32'(evt_n));
      n0 = evt_n;
      wb(pch_pkg::OFS_CMD, 1'b1, 32'h4);
      wait_evt(n0);
      wb(pch_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("refresh acked", 32'h20, q & 32'h28);
      chk("wdata req seen", 32'h10, q & 32'h10);
      wb(pch_pkg::OFS_STATUS, 1'b1, 32'h20);
      wb(pch_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("refresh cleared", 32'h0, q & 32'h20);
      finish_test();
   end
endmodule
